// File: common/fault_regs_pkg.sv
/*
  Constants shared by the fault flag and fault mask register pair:
  command codes, bit positions, reset values and hiccup timing.
  Assumes a 200 MHz reference clock and a serial front end that has
  already decoded each command into a code, a direction and a word.
*/
// What this block does
// RQ1: A status bit reads 1 once its fault was seen since last clear.
// RQ2: Eight protection fault flags sit in status bits nine down to two.
// RQ3: Bits fifteen to ten of status and mask always read zero.
// RQ4: Bit 0 latches a comms warning on unsupported command or bad PEC.
// RQ5: Bit 1 latches the thermistor warning from its comparator.
// RQ6: Bit 2 latches the input overvoltage fault.
// RQ7: Bit 3 latches the thermistor over-temperature fault.
// RQ8: Bit 4 latches the average input overcurrent fault.
// RQ9: Bit 5 latches peak overcurrent; any single phase sets it.
// RQ10: Bit 6 latches the output undervoltage fault.
// RQ11: Bit 7 latches the output overvoltage fault.
// RQ12: Bit 8 latches the loop-filter short fault.
// RQ13: Bit 9 latches the loop lock fault at minimum frequency.
// RQ14: A masked fault causes no action; switching continues.
// RQ15: An unmasked fault stops switching, then hiccup or latch-off.
// RQ16: Mask bits nine to two gate the fault of the same position.
// RQ17: Mask resets to 0049h, so output undervoltage is ignored.
// RQ18: Reset mask also sets bit 3 and reserved bit 0.
// RQ19: Hiccup stops switching, restarts after 500 ms, repeats while faulted.
// RQ20: A set fault flag pulls the open-drain alert low.
// RQ21: Latch-off holds switching off until enable toggles; bus stays usable.
// RQ22: Flags hold until reset or host write; host writes zero to clear.
package fault_regs_pkg;

  // ----------------------------------------------------------------
  // Command codes and widths
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_FAULT_EVENT_FLAGS = 8'hD0;
  localparam logic [7:0]  CMD_FAULT_IGNORE_MASK = 8'hD1;
  localparam int          REG_W                 = 16;
  localparam int          FLAG_MSB              = 9;
  localparam int          PROT_LSB              = 2;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int BIT_COMMS_WARNING      = 0;
  localparam int BIT_THERM_WARNING      = 1;
  localparam int BIT_INPUT_OV           = 2;
  localparam int BIT_THERM_OVERTEMP     = 3;
  localparam int BIT_AVERAGE_OC         = 4;
  localparam int BIT_PEAK_OC            = 5;
  localparam int BIT_OUTPUT_UV          = 6;
  localparam int BIT_OUTPUT_OV          = 7;
  localparam int BIT_LOOP_FILTER_SHORT  = 8;
  localparam int BIT_LOOP_LOCK          = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET  = 16'h0049;

  // ----------------------------------------------------------------
  // Hiccup timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int HICCUP_MS      = 500;
  localparam int HICCUP_CYCLES  = HICCUP_MS * 1000 * CLK_MHZ;

  // Protection sequencer states
  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_RUN     = 2'b01,
    ST_HICCUP  = 2'b10,
    ST_LATCHED = 2'b11
  } prot_state_e;

endpackage

// File: common/fault_if.sv
/*
  Carrier between the top of the fault register pair and its flag
  store and protection sequencer. Assumes one clock for all parties.
*/
`timescale 1ns/10ps
`default_nettype none
interface fault_if;
  logic [9:0] cond;        // Live detector levels, bits 9:0
  logic       wr_flags;    // Host write to the status word
  logic [9:0] wdata;       // Written status bits
  logic [9:0] flags;       // Sticky flags
  logic [9:2] mask;        // Ignore bits
  logic [9:2] hiccup_sel;  // 1 = hiccup, 0 = latch-off
  logic       enable;      // Enable input level
  logic       switch_en;   // Switching allowed
  logic       restart;     // Soft-start request pulse
  fault_regs_pkg::prot_state_e state;

  modport store (input cond, wr_flags, wdata, output flags);
  modport seq   (input cond, mask, hiccup_sel, enable,
                 output switch_en, restart, state);
  modport top   (output cond, wr_flags, wdata, mask, hiccup_sel, enable,
                 input flags, switch_en, restart, state);
endinterface
`default_nettype wire

// File: rtl/fault_flag_store.sv
/*
  Sticky fault flags. Assumes detector levels are synchronous and that
  the top issues one write strobe per host write of the status word.
*/
`timescale 1ns/10ps
`default_nettype none
module fault_flag_store (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Carrier
  fault_if.store    bus
);

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  logic [9:0] flags_r;
  logic [9:0] flags_nxt;

  // Write keeps only bits written as one; a detection in the same
  // cycle wins so no event is lost
  always_comb begin
    flags_nxt = bus.wr_flags ? (flags_r & bus.wdata) : flags_r; // RQ22
    flags_nxt = flags_nxt | bus.cond;                           // RQ1 RQ2
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_r <= fault_regs_pkg::FLAGS_RESET[9:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign bus.flags = flags_r;

endmodule // fault_flag_store
`default_nettype wire

// File: rtl/fault_protect_seq.sv
/*
  Protection sequencer: run, hiccup, latch-off. Assumes the enable
  level comes from the enable pin and the hiccup selection from the
  fault response register held elsewhere.
*/
`timescale 1ns/10ps
`default_nettype none
module fault_protect_seq #(
  parameter int HICCUP_CYCLES = fault_regs_pkg::HICCUP_CYCLES
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Carrier
  fault_if.seq      bus
);

  localparam int CNT_W = $clog2(HICCUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HICCUP_CYCLES - 1);

  fault_regs_pkg::prot_state_e state_r;
  logic [CNT_W-1:0]            cnt_r;
  logic                        switch_r;
  logic                        restart_r;
  logic                        trip;
  logic                        latch_req;

  // Masked faults never trip; latch-off if any tripping fault asks it
  assign trip      = |(bus.cond[9:2] & ~bus.mask);                  // RQ14 RQ16
  assign latch_req = |(bus.cond[9:2] & ~bus.mask & ~bus.hiccup_sel); // RQ15

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r   <= fault_regs_pkg::ST_OFF;
      cnt_r     <= '0;
      switch_r  <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      case (state_r)
        fault_regs_pkg::ST_OFF: begin
          if (bus.enable) begin
            state_r   <= fault_regs_pkg::ST_RUN;
            switch_r  <= 1'b1;
            restart_r <= 1'b1;
          end
        end
        fault_regs_pkg::ST_RUN: begin
          if (!bus.enable) begin
            state_r  <= fault_regs_pkg::ST_OFF;
            switch_r <= 1'b0;
          end else if (latch_req) begin
            state_r  <= fault_regs_pkg::ST_LATCHED; // RQ15
            switch_r <= 1'b0;
          end else if (trip) begin
            state_r  <= fault_regs_pkg::ST_HICCUP;  // RQ19
            switch_r <= 1'b0;
            cnt_r    <= '0;
          end
        end
        fault_regs_pkg::ST_HICCUP: begin
          if (!bus.enable) begin
            state_r <= fault_regs_pkg::ST_OFF;
          end else if (latch_req) begin
            state_r <= fault_regs_pkg::ST_LATCHED;
          end else if (cnt_r == CNT_LAST) begin
            // Still faulted: wait another full period
            cnt_r <= '0;
            if (!trip) begin
              state_r   <= fault_regs_pkg::ST_RUN; // RQ19
              switch_r  <= 1'b1;
              restart_r <= 1'b1;
            end
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        fault_regs_pkg::ST_LATCHED: begin
          // Only an enable toggle leaves latch-off
          if (!bus.enable) begin
            state_r <= fault_regs_pkg::ST_OFF; // RQ21
          end
        end
        default: begin
          state_r  <= fault_regs_pkg::ST_OFF;
          switch_r <= 1'b0;
        end
      endcase
    end
  end

  assign bus.switch_en = switch_r;
  assign bus.restart   = restart_r;
  assign bus.state     = state_r;

endmodule // fault_protect_seq
`default_nettype wire

// File: rtl/fault_flag_and_mask_regs.sv
/*
  Fault flag and fault mask command registers of a two-phase boost
  controller, with the protective response they steer.
  Assumes a serial front end that hands over each command to this
  block as a one-cycle strobe with code, direction and 16-bit word,
  and that flags unsupported commands and PEC errors as pulses.
  Detector inputs are synchronous levels, high while the condition
  holds.
*/
`timescale 1ns/10ps
`default_nettype none
module fault_flag_and_mask_regs #(
  parameter int N_PHASE       = 2,
  parameter int HICCUP_CYCLES = fault_regs_pkg::HICCUP_CYCLES
) (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,

  // Decoded command port from the serial front end
  input  wire logic               i_cmd_valid,
  input  wire logic               i_cmd_write,
  input  wire logic [7:0]         i_cmd_code,
  input  wire logic [15:0]        i_cmd_wdata,
  input  wire logic               i_cmd_unsupported,
  input  wire logic               i_pec_error,

  // Command answers
  output logic                    o_cmd_ack,
  output logic                    o_cmd_miss,
  output logic                    o_rd_valid,
  output logic [15:0]             o_rd_data,

  // Detector levels
  input  wire logic               i_thermistor_warning_flag,
  input  wire logic               i_input_overvoltage_fault,
  input  wire logic               i_thermistor_overtemp_fault,
  input  wire logic               i_average_overcurrent_fault,
  input  wire logic [N_PHASE-1:0] i_peak_overcurrent_phase,
  input  wire logic               i_output_undervoltage_fault,
  input  wire logic               i_output_overvoltage_fault,
  input  wire logic               i_loop_filter_short_fault,
  input  wire logic               i_loop_lock_fault,

  // Sequencer inputs
  input  wire logic               i_enable,
  input  wire logic [9:2]         i_hiccup_select,

  // Switching control
  output logic                    o_switch_en,
  output logic                    o_softstart_restart,
  output logic [1:0]              o_prot_state,

  // Open-drain alert pin
  input  wire logic               i_alert_output,
  output logic                    o_alert_output,
  output logic                    o_alert_output_oe_n
);

  // ----------------------------------------------------------------
  // Local decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] ref_code);
    is_cmd = (code == ref_code);
  endfunction

  fault_if fbus ();

  logic       hit_flags;
  logic       hit_mask;
  logic [9:0] mask_r;
  logic [9:0] cond;
  logic       comms_evt;
  logic       peak_any;
  logic       alert_sense_r;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign hit_flags = i_cmd_valid && is_cmd(i_cmd_code, fault_regs_pkg::CMD_FAULT_EVENT_FLAGS);
  assign hit_mask  = i_cmd_valid && is_cmd(i_cmd_code, fault_regs_pkg::CMD_FAULT_IGNORE_MASK);

  // ----------------------------------------------------------------
  // Detector gathering
  // ----------------------------------------------------------------
  // Any one phase is enough to set the shared peak flag
  assign peak_any  = |i_peak_overcurrent_phase;                    // RQ9
  // Comms warning is an event, not a level
  assign comms_evt = i_cmd_unsupported | i_pec_error;              // RQ4

  always_comb begin
    cond                                        = '0;
    cond[fault_regs_pkg::BIT_COMMS_WARNING]     = comms_evt;                   // RQ4
    cond[fault_regs_pkg::BIT_THERM_WARNING]     = i_thermistor_warning_flag;   // RQ5
    cond[fault_regs_pkg::BIT_INPUT_OV]          = i_input_overvoltage_fault;   // RQ6
    cond[fault_regs_pkg::BIT_THERM_OVERTEMP]    = i_thermistor_overtemp_fault; // RQ7
    cond[fault_regs_pkg::BIT_AVERAGE_OC]        = i_average_overcurrent_fault; // RQ8
    cond[fault_regs_pkg::BIT_PEAK_OC]           = peak_any;                    // RQ9
    cond[fault_regs_pkg::BIT_OUTPUT_UV]         = i_output_undervoltage_fault; // RQ10
    cond[fault_regs_pkg::BIT_OUTPUT_OV]         = i_output_overvoltage_fault;  // RQ11
    cond[fault_regs_pkg::BIT_LOOP_FILTER_SHORT] = i_loop_filter_short_fault;   // RQ12
    cond[fault_regs_pkg::BIT_LOOP_LOCK]         = i_loop_lock_fault;           // RQ13
  end

  // ----------------------------------------------------------------
  // Carrier hookup
  // ----------------------------------------------------------------
  assign fbus.cond       = cond;
  assign fbus.wr_flags   = hit_flags && i_cmd_write;                // RQ22
  assign fbus.wdata      = i_cmd_wdata[9:0];
  assign fbus.mask       = mask_r[9:2];                             // RQ16
  assign fbus.hiccup_sel = i_hiccup_select;
  assign fbus.enable     = i_enable;

  fault_flag_store u_store (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (fbus.store)
  );

  fault_protect_seq #(
    .HICCUP_CYCLES (HICCUP_CYCLES)
  ) u_seq (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (fbus.seq)
  );

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  // Upper bits are not stored at all, so they cannot read back set
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= fault_regs_pkg::MASK_RESET[9:0];  // RQ17 RQ18
    end else if (hit_mask && i_cmd_write) begin
      mask_r <= i_cmd_wdata[9:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  // Reads answer one cycle after the strobe; the flag read shows the
  // flag register before any same-cycle detection lands
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 16'h0000;
    end else begin
      o_rd_valid <= (hit_flags || hit_mask) && !i_cmd_write;
      if (hit_flags && !i_cmd_write) begin
        o_rd_data <= {6'h00, fbus.flags};          // RQ3
      end else if (hit_mask && !i_cmd_write) begin
        o_rd_data <= {6'h00, mask_r};              // RQ3
      end
    end
  end

  // Codes this block does not own are reported, not answered
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_ack  <= 1'b0;
      o_cmd_miss <= 1'b0;
    end else begin
      o_cmd_ack  <= hit_flags || hit_mask;
      o_cmd_miss <= i_cmd_valid && !hit_flags && !hit_mask;
    end
  end

  // ----------------------------------------------------------------
  // Switching outputs
  // ----------------------------------------------------------------
  // Re-registered so the pins stay glitch free; costs one cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_switch_en         <= 1'b0;
      o_softstart_restart <= 1'b0;
      o_prot_state        <= 2'b00;
    end else begin
      o_switch_en         <= fbus.switch_en;       // RQ14 RQ15
      o_softstart_restart <= fbus.restart;         // RQ19
      o_prot_state        <= fbus.state;           // RQ21
    end
  end

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  // Pulled low while any flag is set, released once the host clears
  // them all; the pin level is sampled into alert_sense_r, which nothing reads
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_alert_output      <= 1'b0;
      o_alert_output_oe_n <= 1'b1;
      alert_sense_r       <= 1'b1;
    end else begin
      o_alert_output      <= 1'b0;
      o_alert_output_oe_n <= ~(|fbus.flags);       // RQ20
      alert_sense_r       <= i_alert_output;
    end
  end

endmodule // fault_flag_and_mask_regs
`default_nettype wire

// File: test/host_cmd_model.sv
/*
  Host side model: issues whole decoded commands to the register block.
  Assumes one clock and answers registered on the taking edge itself.
*/
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
  // Clock
  input  wire logic        i_ref_clk,
  // Answers from the block
  input  wire logic        i_ack,
  input  wire logic        i_miss,
  input  wire logic [15:0] i_rd_data,
  // Command strobe to the block
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_code,
  output logic [15:0]      o_wdata
);
  // ------------------------------------------
  // Idle state and one transfer
  // ------------------------------------------
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code = 8'h00;
    o_wdata = 16'h0000;
  end

  // Strobe for one edge; answer read in the next cycle
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ack, output logic miss);
    @(posedge i_ref_clk);
    o_valid <= 1'b1;
    o_write <= wr;
    o_code <= code;
    o_wdata <= wd;
    @(posedge i_ref_clk);
    o_valid <= 1'b0;
    o_code <= ~code;  // Released code and data lines never keep the old value
    o_wdata <= ~wd;
    #1;
    ack = i_ack;
    miss = i_miss;
    rd = i_rd_data;
  endtask
endmodule // host_cmd_model
`default_nettype wire

// File: test/fault_regs_checker.sv
/*
  Port-level checks of the fault flag and mask registers.
  Assumes one reference clock and an active-high async reset.
*/
`timescale 1ns/10ps
`default_nettype none
module fault_regs_checker #(
  parameter int N_PHASE = 2
) (
  // Clock, reset and commands
  input wire logic               i_ref_clk,
  input wire logic               i_rst,
  input wire logic               i_cmd_valid,
  input wire logic               i_cmd_write,
  input wire logic [7:0]         i_cmd_code,
  input wire logic               i_cmd_unsupported,
  input wire logic               i_pec_error,
  // Detectors and enable
  input wire logic               i_thermistor_warning_flag,
  input wire logic               i_input_overvoltage_fault,
  input wire logic               i_thermistor_overtemp_fault,
  input wire logic               i_average_overcurrent_fault,
  input wire logic [N_PHASE-1:0] i_peak_overcurrent_phase,
  input wire logic               i_output_undervoltage_fault,
  input wire logic               i_output_overvoltage_fault,
  input wire logic               i_loop_filter_short_fault,
  input wire logic               i_loop_lock_fault,
  input wire logic               i_enable,
  // Outputs watched
  input wire logic               o_cmd_ack,
  input wire logic               o_cmd_miss,
  input wire logic               o_rd_valid,
  input wire logic [15:0]        o_rd_data,
  input wire logic               o_switch_en,
  input wire logic               o_softstart_restart,
  input wire logic [1:0]         o_prot_state,
  input wire logic               o_alert_output_oe_n
);
  // ------------------------------------------
  // Helper terms
  // ------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic known = i_cmd_valid && (i_cmd_code == 8'hD0 || i_cmd_code == 8'hD1);
  wire logic rd_cmd = known && !i_cmd_write;
  wire logic any_det = |{i_cmd_unsupported, i_pec_error, i_thermistor_warning_flag,
                         i_input_overvoltage_fault, i_thermistor_overtemp_fault,
                         i_average_overcurrent_fault, i_peak_overcurrent_phase,
                         i_output_undervoltage_fault, i_output_overvoltage_fault,
                         i_loop_filter_short_fault, i_loop_lock_fault};

  // ------------------------------------------
  // Assertions
  // ------------------------------------------
  a_known_cmd_ack: assert property (known |=> o_cmd_ack && !o_cmd_miss)
    else $error("register command not acknowledged");
  a_other_cmd_miss: assert property (i_cmd_valid && !known |=> o_cmd_miss && !o_cmd_ack)
    else $error("unknown command not refused");
  a_read_answer: assert property (o_rd_valid == $past(rd_cmd))
    else $error("read answer out of step with read command");
  a_upper_bits_zero: assert property (o_rd_valid |-> o_rd_data[15:10] == 6'h00)
    else $error("unused upper bits read nonzero");
  a_detect_alert: assert property (any_det |-> ##2 !o_alert_output_oe_n)
    else $error("alert not pulled after a detection");
  a_hiccup_stops: assert property (o_prot_state == 2'b10 |-> !o_switch_en)
    else $error("switching during hiccup");
  a_hiccup_wait: assert property ($rose(o_prot_state == 2'b10) |-> (!o_switch_en) [*8])
    else $error("hiccup off time too short");
  a_latch_holds: assert property (o_prot_state == 2'b11 && i_enable && $past(i_enable)
                                  |=> o_prot_state == 2'b11)
    else $error("latch-off left without enable toggle");
  a_enable_low_off: assert property (!i_enable |-> ##2 !o_switch_en)
    else $error("switching with enable low");
  a_restart_pulse: assert property ($rose(o_switch_en)
                                    |-> o_softstart_restart || $past(o_softstart_restart))
    else $error("start without soft-start pulse");

  // Main scenarios reached
  c_hiccup: cover property (o_prot_state == 2'b10);
  c_latched: cover property (o_prot_state == 2'b11);
  c_miss: cover property (o_cmd_miss);
endmodule // fault_regs_checker

bind fault_flag_and_mask_regs fault_regs_checker #(.N_PHASE(N_PHASE)) i_fault_regs_checker (.*);
`default_nettype wire

// File: test/fault_flag_and_mask_regs_bench.sv
/*
  Self-checking bench for the fault flag and mask registers.
  Assumes the host command model beside it and a pulled-up alert pin.
*/
`timescale 1ns/10ps
`default_nettype none
module fault_flag_and_mask_regs_bench;
  // ------------------------------------------
  // Signals and reference model
  // ------------------------------------------
  localparam int HICC = 16;  // Short hiccup so the run stays brief
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_enable = 1'b1;
  logic [9:2]  i_hiccup_select = 8'hFF;
  logic [11:0] src = 12'h000;
  wire logic   i_cmd_valid, i_cmd_write, i_cmd_unsupported, i_pec_error;
  wire logic   i_thermistor_warning_flag, i_input_overvoltage_fault;
  wire logic   i_thermistor_overtemp_fault, i_average_overcurrent_fault;
  wire logic   i_output_undervoltage_fault, i_output_overvoltage_fault;
  wire logic   i_loop_filter_short_fault, i_loop_lock_fault;
  wire logic [1:0]  i_peak_overcurrent_phase;
  wire logic [7:0]  i_cmd_code;
  wire logic [15:0] i_cmd_wdata;
  logic        o_cmd_ack, o_cmd_miss, o_rd_valid, o_switch_en, o_softstart_restart;
  logic        o_alert_output, o_alert_output_oe_n;
  logic [1:0]  o_prot_state;
  logic [15:0] o_rd_data, rdat;
  logic [15:0] m_flags = 16'h0000;
  logic [15:0] m_mask = 16'h0049;
  logic        ack, miss;
  int          fails = 0, compares = 0, n = 0, seed = 32'hde11;

  // Pin pulled up; the block only ever pulls it low
  wire logic i_alert_output = o_alert_output_oe_n ? 1'b1 : o_alert_output;
  // One-hot flag sources: comms pulses, then status bits 1 to 9, then phase 1
  assign {i_peak_overcurrent_phase[1], i_loop_lock_fault, i_loop_filter_short_fault,
          i_output_overvoltage_fault, i_output_undervoltage_fault,
          i_peak_overcurrent_phase[0], i_average_overcurrent_fault,
          i_thermistor_overtemp_fault, i_input_overvoltage_fault,
          i_thermistor_warning_flag, i_pec_error, i_cmd_unsupported} = src;

  always #2.5 i_ref_clk = ~i_ref_clk;

  fault_flag_and_mask_regs #(.HICCUP_CYCLES(HICC)) i_fault_flag_and_mask_regs (.*);

  host_cmd_model i_host_cmd_model (
    .i_ref_clk, .i_ack(o_cmd_ack), .i_miss(o_cmd_miss), .i_rd_data(o_rd_data),
    .o_valid(i_cmd_valid), .o_write(i_cmd_write), .o_code(i_cmd_code), .o_wdata(i_cmd_wdata)
  );

  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    i_host_cmd_model.xfer(1'b0, code, 16'h0000, rdat, ack, miss);
    check(16'(ack), 16'h0001);
    check(rdat, exp);
  endtask

  // Model: flags only clear, mask keeps bits 9:0
  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    i_host_cmd_model.xfer(1'b1, code, d, rdat, ack, miss);
    check(16'(ack), 16'h0001);
    if (code == 8'hD0)
      m_flags = m_flags & d & 16'h03FF;
    else
      m_mask = d & 16'h03FF;
  endtask

  task automatic pulse(input int i);
    @(posedge i_ref_clk);
    src <= 12'h001 << i;
    @(posedge i_ref_clk);
    src <= 12'h000;
    m_flags[i < 2 ? 0 : (i == 11 ? 5 : i - 1)] = 1'b1;
  endtask

  // Bounded wait for the switching level
  task automatic wait_sw(input logic lvl, input int lim);
    n = 0;
    while (o_switch_en !== lvl && n < lim) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic stop_test;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    check(16'(o_switch_en), 16'h0001);
    rd(8'hD0, 16'h0000);
    rd(8'hD1, 16'h0049);
    wr(8'hD1, 16'hFFFF);
    rd(8'hD1, m_mask);
    repeat (4) begin
      wr(8'hD1, 16'($random(seed)) | 16'h03FC);
      rd(8'hD1, m_mask);
    end
    // Every source in turn with all protection masked; flags accumulate
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      rd(8'hD0, m_flags);
      check(16'(i_alert_output), 16'h0000);
      check(16'(o_switch_en), 16'h0001);
    end
    wr(8'hD0, 16'h0108);
    rd(8'hD0, m_flags);
    wr(8'hD0, 16'h0000);
    wr(8'hD0, 16'hFFFF);
    rd(8'hD0, 16'h0000);
    check(16'(i_alert_output), 16'h0001);
    i_host_cmd_model.xfer(1'b0, 8'hD2, 16'h0000, rdat, ack, miss);
    check(16'({ack, miss}), 16'h0001);
    // Only bit 2 unmasked: bit 3 must not trip, bit 2 hiccups
    wr(8'hD1, 16'h03F8);
    pulse(4);
    wait_sw(1'b0, 6);
    check(16'(o_switch_en), 16'h0001);
    pulse(3);
    wait_sw(1'b0, 6);
    check(16'(o_prot_state), 16'h0002);
    wait_sw(1'b1, HICC + 10);
    check(16'(n == HICC), 16'h0001);
    // Latch-off holds after the fault goes; bus stays usable
    @(posedge i_ref_clk);
    i_hiccup_select <= 8'h00;
    pulse(3);
    wait_sw(1'b0, 6);
    repeat (30) @(posedge i_ref_clk);
    #1;
    check(16'(o_prot_state), 16'h0003);
    rd(8'hD0, m_flags);
    @(posedge i_ref_clk);
    i_enable <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_enable <= 1'b1;
    wait_sw(1'b1, 10);
    check(16'(o_switch_en), 16'h0001);
    stop_test;
  end

  // Watchdog far past the few hundred cycles needed
  initial begin
    #(5 * 20000);
    fails++;
    stop_test;
  end
endmodule // fault_flag_and_mask_regs_bench
`default_nettype wire
